// ### dij_pkg.sv
// constants, types and register map shared by the jump/increment/decrement core
// assumes: nothing; every user writes dij_pkg::name
package dij_pkg;
  // widths
  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int LIT_W = 11;
  localparam int LATCH_W = 5;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int FILE_DEPTH = 128;
  // instruction field positions
  localparam int OPC6_HI = 13;
  localparam int OPC6_LO = 8;
  localparam int OPC3_LO = 11;
  localparam int DEST_POS = 7;
  localparam int FADDR_HI = 6;
  localparam int LIT_HI = 10;
  localparam int PAGE_HI = 4;
  localparam int PAGE_LO = 3;
  // opcodes
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OPC_INC = 6'h0A;
  localparam logic [2:0] OPC_JUMP = 3'h5;
  localparam logic DEST_WORK = 1'h0;
  // arithmetic and reset values
  localparam logic [7:0] DATA_ONE = 8'h01;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [13:0] WORD_RST = 14'h0000;
  localparam logic [4:0] LATCH_RST = 5'h00;
  localparam logic [6:0] FADDR_RST = 7'h00;
  localparam logic [31:0] APB_ZERO = 32'h00000000;
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LATCH = 8'h04;
  localparam logic [7:0] OFF_WORK = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam logic [7:0] OFF_FADDR = 8'h14;
  localparam logic [7:0] OFF_FDATA = 8'h18;
  localparam logic [7:0] OFF_WORD = 8'h1C;
  // bit positions
  localparam int CTRL_RUN = 0;
  localparam int STAT_ZERO = 0;
  localparam int STAT_PFVALID = 1;
  localparam int STAT_RUN = 2;
  typedef enum logic {EXEC_HALTED, EXEC_ACTIVE} dij_exec_state_t;
endpackage : dij_pkg

// ### dij_exec_if.sv
// carrier between the core, its decoder and its data-memory file
// assumes: the core drives word and file ports, the others answer combinationally
`timescale 1ns/1ns
interface dij_exec_if;
  logic [dij_pkg::WORD_W-1:0] word;
  logic isDecSkip;
  logic isInc;
  logic isJump;
  logic dest;
  logic [dij_pkg::FADDR_W-1:0] fileAddr;
  logic [dij_pkg::LIT_W-1:0] lit;
  logic [dij_pkg::FADDR_W-1:0] rdAddrA;
  logic [dij_pkg::FADDR_W-1:0] rdAddrB;
  logic [dij_pkg::FADDR_W-1:0] wrAddr;
  logic [dij_pkg::DATA_W-1:0] rdDataA;
  logic [dij_pkg::DATA_W-1:0] rdDataB;
  logic [dij_pkg::DATA_W-1:0] wrData;
  logic wrEn;
  modport core(output word, rdAddrA, rdAddrB, wrAddr, wrData, wrEn,
               input isDecSkip, isInc, isJump, dest, fileAddr, lit, rdDataA, rdDataB);
  modport dec(input word, output isDecSkip, isInc, isJump, dest, fileAddr, lit);
  modport rf(input rdAddrA, rdAddrB, wrAddr, wrData, wrEn, output rdDataA, rdDataB);
endinterface : dij_exec_if

// ### dij_decoder.sv
// combinational decode of the three handled instruction words
// assumes: word is the prefetched instruction, other opcodes decode to nothing
`timescale 1ns/1ns
module dij_decoder (
  dij_exec_if.dec bus
);
  // --------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------
  assign bus.isDecSkip = bus.word[dij_pkg::OPC6_HI:dij_pkg::OPC6_LO] == dij_pkg::OPC_DEC_SKIP;
  assign bus.isInc = bus.word[dij_pkg::OPC6_HI:dij_pkg::OPC6_LO] == dij_pkg::OPC_INC;
  assign bus.isJump = bus.word[dij_pkg::OPC6_HI:dij_pkg::OPC3_LO] == dij_pkg::OPC_JUMP;
  assign bus.dest = bus.word[dij_pkg::DEST_POS];
  assign bus.fileAddr = bus.word[dij_pkg::FADDR_HI:0];
  assign bus.lit = bus.word[dij_pkg::LIT_HI:0];
endmodule : dij_decoder

// ### dij_regfile.sv
// 128 x 8 data-memory file: two combinational read ports, one write port
// assumes: synchronous reset release, ce freezes contents
`timescale 1ns/1ns
module dij_regfile (
  input wire logic clk,
  input wire logic rstSyncN,
  input wire logic ce,
  dij_exec_if.rf bus
);
  typedef struct packed {
    logic [dij_pkg::FILE_DEPTH-1:0][dij_pkg::DATA_W-1:0] mem;
  } dij_file_t;

  dij_file_t s;
  dij_file_t next_s;

  // --------------------------------------------------------------
  // read and write
  // --------------------------------------------------------------
  assign bus.rdDataA = s.mem[bus.rdAddrA];
  assign bus.rdDataB = s.mem[bus.rdAddrB];

  always_comb begin
    next_s = s;
    if (bus.wrEn) begin
      next_s.mem[bus.wrAddr] = bus.wrData;
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
endmodule : dij_regfile

// ### dij_core.sv
// execution core for decrement-skip, increment and unconditional jump
// assumes: program memory answers progAddr combinationally on progData,
// APB master per AMBA, ce freezes every state flop except the reset synchroniser
`timescale 1ns/1ns
module dij_core (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [dij_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dij_pkg::APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [dij_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [dij_pkg::PC_W-1:0] progAddr,
  input wire logic [dij_pkg::WORD_W-1:0] progData,
  output logic [dij_pkg::DATA_W-1:0] workReg,
  output logic zeroFlag,
  output logic skipTaken,
  output logic jumpTaken
);
  // --------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------
  logic [1:0] rstPipe;
  logic rstSyncN;

  // the synchroniser ignores ce so that a frozen core still leaves reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'h1};
    end
  end

  assign rstSyncN = rstPipe[1];

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  // pulses last one cycle; every other field holds until it is changed
  typedef struct packed {
    dij_pkg::dij_exec_state_t st;
    logic [dij_pkg::PC_W-1:0] pc;
    logic [dij_pkg::WORD_W-1:0] pfWord;
    logic pfValid;
    logic [dij_pkg::DATA_W-1:0] w;
    logic z;
    logic [dij_pkg::LATCH_W-1:0] latch;
    logic [dij_pkg::FADDR_W-1:0] memAddr;
    logic [dij_pkg::APB_DW-1:0] rdata;
    logic slverr;
    logic skipPulse;
    logic jumpPulse;
  } dij_core_t;

  localparam dij_core_t CORE_RST = '{
    st: dij_pkg::EXEC_HALTED,
    pc: dij_pkg::PC_RST,
    pfWord: dij_pkg::WORD_RST,
    pfValid: 1'h0,
    w: dij_pkg::DATA_ZERO,
    z: 1'h0,
    latch: dij_pkg::LATCH_RST,
    memAddr: dij_pkg::FADDR_RST,
    rdata: dij_pkg::APB_ZERO,
    slverr: 1'h0,
    skipPulse: 1'h0,
    jumpPulse: 1'h0
  };

  dij_core_t s;
  dij_core_t next_s;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic addrMapped(input logic [dij_pkg::APB_AW-1:0] a);
    logic hit;
    hit = 1'h0;
    case (a)
      dij_pkg::OFF_CTRL,
      dij_pkg::OFF_LATCH,
      dij_pkg::OFF_WORK,
      dij_pkg::OFF_STATUS,
      dij_pkg::OFF_PC,
      dij_pkg::OFF_FADDR,
      dij_pkg::OFF_FDATA,
      dij_pkg::OFF_WORD: hit = 1'h1;
      default: hit = 1'h0;
    endcase
    return hit;
  endfunction : addrMapped

  function automatic logic isRunning(input dij_pkg::dij_exec_state_t st);
    return st == dij_pkg::EXEC_ACTIVE;
  endfunction : isRunning

  // jump target: page bits from the latch above the literal
  function automatic logic [dij_pkg::PC_W-1:0] pageTarget(input logic [dij_pkg::LATCH_W-1:0] l,
                                                          input logic [dij_pkg::LIT_W-1:0] k);
    return {l[dij_pkg::PAGE_HI:dij_pkg::PAGE_LO], k};
  endfunction : pageTarget

  // byte lanes not strobed keep the current value
  function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction : mergeWord

  // --------------------------------------------------------------
  // decoder and data-memory file
  // --------------------------------------------------------------
  // the decoder and the file answer combinationally within the cycle
  dij_exec_if x ();

  dij_decoder u_dec (
    .bus(x)
  );

  dij_regfile u_file (
    .clk(core_clk),
    .rstSyncN(rstSyncN),
    .ce(ce),
    .bus(x)
  );

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  logic apbSetup;
  logic apbWrite;
  logic apbFileWr;
  logic apbPcWr;
  logic [31:0] readWord;
  logic [31:0] wrWord;

  // read data is a snapshot taken in the setup phase, so a read may show
  // the value of one cycle earlier
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite && addrMapped(paddr);
  assign apbFileWr = apbWrite && (paddr == dij_pkg::OFF_FDATA);
  assign apbPcWr = apbWrite && (paddr == dij_pkg::OFF_PC);

  always_comb begin
    readWord = dij_pkg::APB_ZERO;
    case (paddr)
      dij_pkg::OFF_CTRL: begin
        readWord[dij_pkg::CTRL_RUN] = isRunning(s.st);
      end
      dij_pkg::OFF_LATCH: begin
        readWord[dij_pkg::LATCH_W-1:0] = s.latch;
      end
      dij_pkg::OFF_WORK: begin
        readWord[dij_pkg::DATA_W-1:0] = s.w;
      end
      dij_pkg::OFF_STATUS: begin
        readWord[dij_pkg::STAT_ZERO] = s.z;
        readWord[dij_pkg::STAT_PFVALID] = s.pfValid;
        readWord[dij_pkg::STAT_RUN] = isRunning(s.st);
      end
      dij_pkg::OFF_PC: begin
        readWord[dij_pkg::PC_W-1:0] = s.pc;
      end
      dij_pkg::OFF_FADDR: begin
        readWord[dij_pkg::FADDR_W-1:0] = s.memAddr;
      end
      dij_pkg::OFF_FDATA: begin
        readWord[dij_pkg::DATA_W-1:0] = x.rdDataB;
      end
      dij_pkg::OFF_WORD: begin
        readWord[dij_pkg::WORD_W-1:0] = s.pfWord;
      end
      default: begin
        readWord = dij_pkg::APB_ZERO;
      end
    endcase
  end

  assign wrWord = mergeWord(readWord, pwdata, pstrb);

  // --------------------------------------------------------------
  // execution datapath
  // --------------------------------------------------------------
  logic stall;
  logic step;
  logic exec;
  logic aluOp;
  logic execDecSkip;
  logic execInc;
  logic execJump;
  logic skipNow;
  logic wrWorkReg;
  logic coreFileWr;
  logic [dij_pkg::DATA_W-1:0] operand;
  logic [dij_pkg::DATA_W-1:0] decResult;
  logic [dij_pkg::DATA_W-1:0] incResult;
  logic [dij_pkg::DATA_W-1:0] result;
  logic resultZero;
  logic [dij_pkg::PC_W-1:0] jumpTarget;

  // pipeline: every step loads the word at pc into the prefetch register and
  // advances pc while the word loaded by the step before executes; a skip or
  // a jump clears the valid bit, so the step after retires nothing
  // a software write to the file or the counter takes this cycle from the core
  assign stall = apbFileWr || apbPcWr;
  assign step = isRunning(s.st) && !stall;
  assign exec = step && s.pfValid;
  assign aluOp = exec && (x.isDecSkip || x.isInc);
  assign execDecSkip = exec && x.isDecSkip;
  assign execInc = exec && x.isInc;
  assign execJump = exec && x.isJump;
  assign operand = x.rdDataA;
  assign decResult = operand - dij_pkg::DATA_ONE;
  // eight-bit arithmetic wraps all ones to zero by itself
  assign incResult = operand + dij_pkg::DATA_ONE;
  assign result = x.isDecSkip ? decResult : incResult;
  assign resultZero = result == dij_pkg::DATA_ZERO;
  assign skipNow = execDecSkip && resultZero;
  assign wrWorkReg = aluOp && (x.dest == dij_pkg::DEST_WORK);
  assign coreFileWr = aluOp && (x.dest != dij_pkg::DEST_WORK);
  assign jumpTarget = pageTarget(s.latch, x.lit);

  // file port A serves the executing word, port B the software window
  assign x.word = s.pfWord;
  assign x.rdAddrA = x.fileAddr;
  assign x.rdAddrB = s.memAddr;
  assign x.wrEn = coreFileWr || apbFileWr;
  assign x.wrAddr = coreFileWr ? x.fileAddr : s.memAddr;
  assign x.wrData = coreFileWr ? result : wrWord[dij_pkg::DATA_W-1:0];

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.skipPulse = 1'h0;
    next_s.jumpPulse = 1'h0;

    // read data and error are captured in the setup phase
    if (apbSetup) begin
      next_s.rdata = readWord;
      next_s.slverr = !addrMapped(paddr);
    end

    // read-only fields and unmapped offsets ignore writes
    if (apbWrite) begin
      case (paddr)
        dij_pkg::OFF_CTRL: begin
          next_s.st = wrWord[dij_pkg::CTRL_RUN] ? dij_pkg::EXEC_ACTIVE : dij_pkg::EXEC_HALTED;
        end
        dij_pkg::OFF_LATCH: begin
          next_s.latch = wrWord[dij_pkg::LATCH_W-1:0];
        end
        dij_pkg::OFF_WORK: begin
          next_s.w = wrWord[dij_pkg::DATA_W-1:0];
        end
        dij_pkg::OFF_STATUS: begin
          next_s.z = wrWord[dij_pkg::STAT_ZERO];
        end
        dij_pkg::OFF_PC: begin
          // redirect: the word already fetched belongs to the old flow
          next_s.pc = wrWord[dij_pkg::PC_W-1:0];
          next_s.pfValid = 1'h0;
        end
        dij_pkg::OFF_FADDR: begin
          next_s.memAddr = wrWord[dij_pkg::FADDR_W-1:0];
        end
        default: begin
          next_s.st = s.st;
        end
      endcase
    end

    // core updates come last so that they win over software in the same cycle
    if (step) begin
      next_s.pfWord = progData;
      next_s.pfValid = 1'h1;
      next_s.pc = s.pc + dij_pkg::PC_STEP;
      if (wrWorkReg) begin
        next_s.w = result;
      end
      if (execInc) begin
        next_s.z = resultZero;
      end
      // the word behind a zero decrement result turns into the empty cycle
      if (skipNow) begin
        next_s.pfValid = 1'h0;
        next_s.skipPulse = 1'h1;
      end
      // the sequential word already fetched is flushed
      if (execJump) begin
        next_s.pc = jumpTarget;
        next_s.pfValid = 1'h0;
        next_s.jumpPulse = 1'h1;
      end
    end
  end

  // ce low holds every field, pulses included
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s <= CORE_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // only pready and pslverr are combinational; they follow ce and the bus
  assign pready = ce;
  assign prdata = s.rdata;
  assign pslverr = s.slverr && psel && penable;
  assign progAddr = s.pc;
  assign workReg = s.w;
  assign zeroFlag = s.z;
  assign skipTaken = s.skipPulse;
  assign jumpTaken = s.jumpPulse;
endmodule : dij_core

// ### dij_core_checker.sv
// assertions on the ports of the decrement-skip / increment / jump core
// assumes: bound to dij_core; ce stays high while the core runs
`timescale 1ns/1ns
module dij_core_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [dij_pkg::PC_W-1:0] progAddr,
  input wire logic [dij_pkg::WORD_W-1:0] progData,
  input wire logic [dij_pkg::DATA_W-1:0] workReg,
  input wire logic zeroFlag,
  input wire logic skipTaken,
  input wire logic jumpTaken
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // steps of one executed word
  // ----------------------------------------
  sequence s_ce3;
    ce && $past(ce) && $past(ce, 2);
  endsequence
  sequence s_run2;
    progAddr == $past(progAddr) + 13'h0001 && $past(progAddr) == $past(progAddr, 2) + 13'h0001;
  endsequence
  sequence s_inc_w_done;
    s_ce3 ##0 s_run2 ##0 (($past(progData, 2) & 14'h3F80) == 14'h0A00)
      ##0 (!$past(skipTaken) && !$past(jumpTaken));
  endsequence
  sequence s_skip;
    skipTaken ##0 s_ce3;
  endsequence
  sequence s_jump;
    jumpTaken ##0 s_ce3;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_jump_code;
    s_jump |-> ($past(progData, 2) & 14'h3800) == 14'h2800;
  endproperty
  property p_jump_lit;
    s_jump |-> progAddr[10:0] == 11'($past(progData, 2));
  endproperty
  property p_jump_flags;
    jumpTaken |-> zeroFlag == $past(zeroFlag);
  endproperty
  property p_skip_code;
    s_skip |-> ($past(progData, 2) & 14'h3F00) == 14'h0B00;
  endproperty
  property p_skip_pc;
    s_skip |-> progAddr == $past(progAddr, 2) + 13'h0002;
  endproperty
  property p_skip_flags;
    skipTaken |-> zeroFlag == $past(zeroFlag);
  endproperty
  property p_skip_w;
    s_skip ##0 (($past(progData, 2) & 14'h0080) == 14'h0000) |-> workReg == 8'h00;
  endproperty
  property p_flush;
    (skipTaken || jumpTaken) |=> $stable(workReg) && $stable(zeroFlag) && !skipTaken && !jumpTaken;
  endproperty
  property p_inc_zero;
    s_inc_w_done |-> zeroFlag == (workReg == 8'h00);
  endproperty
  a_jump_code: assert property (p_jump_code) else $error("jump pulse without jump word");
  a_jump_lit: assert property (p_jump_lit) else $error("jump target low bits wrong");
  a_jump_flags: assert property (p_jump_flags) else $error("jump changed zero flag");
  a_skip_code: assert property (p_skip_code) else $error("skip without skip word");
  a_skip_pc: assert property (p_skip_pc) else $error("skip address wrong");
  a_skip_flags: assert property (p_skip_flags) else $error("skip changed zero flag");
  a_skip_w: assert property (p_skip_w) else $error("skip result not zero in W");
  a_flush: assert property (p_flush) else $error("discarded word had effect");
  a_inc_zero: assert property (p_inc_zero) else $error("zero flag wrong after increment");
endmodule : dij_core_checker

bind dij_core dij_core_checker u_chk (.core_clk(core_clk), .rstn(rstn), .ce(ce),
  .progAddr(progAddr), .progData(progData), .workReg(workReg), .zeroFlag(zeroFlag),
  .skipTaken(skipTaken), .jumpTaken(jumpTaken));

// ### decrement_increment_jump_exec_bench.sv
// self-checking bench: loads a short program, runs it, reads results over APB
// assumes: program memory answers combinationally; ce drops once while halted
`timescale 1ns/1ns
module decrement_increment_jump_exec_bench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] paddr;
  logic psel, penable, pwrite;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic pready, pslverr, zeroFlag, skipTaken, jumpTaken;
  logic [12:0] progAddr, tgt;
  wire logic [13:0] progData;
  logic [7:0] workReg, r5, r7;
  logic [10:0] lit;
  logic [4:0] latch;
  logic [13:0] pmem [8192];
  logic [32:0] notes [$];
  logic [7:0] fAddr [4];
  logic [7:0] fInit [4];
  logic [7:0] fExp [4];
  int fails = 0;
  int n_compared = 0;
  assign progData = pmem[progAddr];
  always #20 core_clk = ~core_clk;
  dij_core u_dut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .progAddr(progAddr), .progData(progData),
    .workReg(workReg), .zeroFlag(zeroFlag), .skipTaken(skipTaken), .jumpTaken(jumpTaken));
  // ----------------------------------------
  // comparison and verdict
  // ----------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic take(input logic [32:0] seen);
    if (notes.size() == 0) begin
      fails++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, 33'h0);
    end else begin
      check(seen, notes.pop_front());
    end
  endtask : take
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // APB master, entered just after a rising edge
  // ----------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    if (!w) notes.push_back(exp);
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  // ----------------------------------------
  // monitor: each read completion or core pulse takes the oldest note
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
      take({pslverr, prdata});
    if (jumpTaken === 1'b1 || skipTaken === 1'b1)
      take({9'h000, workReg, zeroFlag, jumpTaken, skipTaken, progAddr});
  end
  initial begin
    #200000;
    fails++;
    tally_and_finish;
  end
  initial begin
    foreach (pmem[i]) pmem[i] = 14'h0000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    void'($urandom(32'h101966dc));
    r5 = 8'($urandom_range(254, 0));
    r7 = 8'($urandom_range(255, 2));
    // keeps the run after the jump clear of the address wrap
    lit = 11'($urandom_range(1983, 0));
    latch = 5'($urandom) | 5'h10;
    tgt = {latch[4:3], lit};
    fAddr = '{8'h05, 8'h06, 8'h07, 8'h08};
    fInit = '{r5, 8'h01, r7, 8'hFF};
    fExp = '{r5 + 8'h01, 8'h01, r7 - 8'h01, 8'hFF};
    // increment to file, zero-result skip to W, discarded jump, non-skipping decrement to file, wrap into W, jump
    pmem[0] = 14'h0A85;
    pmem[1] = 14'h0B06;
    pmem[2] = 14'h2FFF;
    pmem[3] = 14'h0B87;
    pmem[4] = 14'h0A08;
    pmem[5] = 14'h2800 | 14'(lit);
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(1'b1, dij_pkg::OFF_LATCH, 32'(latch), 33'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, dij_pkg::OFF_FADDR, 32'(fAddr[i]), 33'h0);
      apb(1'b1, dij_pkg::OFF_FDATA, 32'(fInit[i]), 33'h0);
    end
    apb(1'b1, dij_pkg::OFF_PC, 32'h00000000, 33'h0);
    notes.push_back({9'h000, 8'h00, 1'b0, 1'b0, 1'b1, 13'h0003});
    notes.push_back({9'h000, 8'h00, 1'b1, 1'b1, 1'b0, tgt});
    apb(1'b1, dij_pkg::OFF_CTRL, 32'h00000001, 33'h0);
    repeat (20) @(posedge core_clk);
    apb(1'b1, dij_pkg::OFF_CTRL, 32'h00000000, 33'h0);
    check(33'(notes.size()), 33'h0);
    $display("program run done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, dij_pkg::OFF_FADDR, 32'(fAddr[i]), 33'h0);
      apb(1'b0, dij_pkg::OFF_FDATA, 32'h0, {25'h0, fExp[i]});
    end
    apb(1'b0, dij_pkg::OFF_WORK, 32'h0, 33'h0);
    // ce low stretches the access phase: the master must wait for pready
    fork
      apb(1'b0, dij_pkg::OFF_LATCH, 32'h0, {28'h0, latch});
      begin
        @(posedge core_clk);
        ce <= 1'b0;
        repeat (3) @(posedge core_clk);
        ce <= 1'b1;
      end
    join
    apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
    $display("readback done");
    tally_and_finish;
  end
endmodule : decrement_increment_jump_exec_bench
